/* include/pre_map.svh */
// Register offsets, field positions, codes and timing of the rung evaluator
// Assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef PRE_MAP_SVH
`define PRE_MAP_SVH

// Register byte offsets
`define PRE_OFF_CTRL      8'h00
`define PRE_OFF_STATE     8'h04
`define PRE_OFF_VARS      8'h08
`define PRE_OFF_IRQ_STAT  8'h0c
`define PRE_OFF_IRQ_MASK  8'h10
`define PRE_OFF_RUNG_BASE 8'h80

// Control register fields and reset values
`define PRE_CTRL_MODE_LSB 0
`define PRE_CTRL_MODE_MSB 3
`define PRE_CTRL_LAST_LSB 8
`define PRE_CTRL_LAST_MSB 12
`define PRE_CTRL_RESET    32'h0000_0000
`define PRE_MASK_RESET    2'h0
`define PRE_MODE_PLC      4'h5

// Rung word byte fields
`define PRE_RUNG_CA_LSB   24
`define PRE_RUNG_LOG_LSB  16
`define PRE_RUNG_CB_LSB   8
`define PRE_RUNG_ACT_LSB  0

// Logic operators
`define PRE_LOG_OR        8'h00
`define PRE_LOG_AND       8'h01
`define PRE_LOG_XOR       8'h02
`define PRE_LOG_NOR       8'h03

// Condition codes
`define PRE_CND_TRUE      8'h01
`define PRE_CND_IN_BASE   8'h32
`define PRE_CND_VAR_BASE  8'h64

// Action codes
`define PRE_ACT_JOG_REV   8'h05
`define PRE_ACT_JOG_FWD   8'h06
`define PRE_ACT_JOG_EN    8'h12
`define PRE_ACT_FAULT     8'h13
`define PRE_ACT_FWD       8'h14
`define PRE_ACT_REV       8'h15
`define PRE_ACT_ACC_GRP   8'h16
`define PRE_ACT_FLT_RST   8'h17
`define PRE_ACT_PRE_SRC   8'h18
`define PRE_ACT_PRE_B0    8'h19
`define PRE_ACT_PRE_B3    8'h1c
`define PRE_ACT_PTAB_SEL  8'h22
`define PRE_ACT_PTAB_B0   8'h23
`define PRE_ACT_PTAB_B1   8'h24
`define PRE_ACT_VAR_BASE  8'h28
`define PRE_ACT_PLC_RST   8'h45

// Sizes
`define PRE_NUM_VARS      10
`define PRE_NUM_IN        8
`define PRE_RUNG_AW       5
`define PRE_PRESET_ZERO   4'hf

// Interrupt bits
`define PRE_IRQ_SCAN      0
`define PRE_IRQ_FAULT     1

// Scan period
`define PRE_CLK_MHZ       40
`define PRE_SCAN_PERIOD_US 1000
`define PRE_SCAN_CYCLES   (`PRE_SCAN_PERIOD_US * `PRE_CLK_MHZ)

`endif

/* include/pre_pkg.sv */
// Types shared by the rung evaluator modules
// Assumes nothing beyond a SystemVerilog compiler
package pre_pkg;

    typedef enum logic [1:0] {
        SC_IDLE,
        SC_FETCH,
        SC_EXEC,
        SC_COMMIT
    } pre_state_t;

    typedef struct packed {
        logic       runFwd;
        logic       runRev;
        logic       jogEn;
        logic       jogFwd;
        logic       jogRev;
        logic       fault;
        logic       faultReset;
        logic       accelGroup;
        logic       presetSrc;
        logic [3:0] presetIdx;
        logic       ptabSel;
        logic [1:0] ptabIdx;
    } pre_act_t;

endpackage

/* include/pre_mem_if.sv */
// Carrier between the evaluator and its rung memory
// Assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface pre_mem_if;
    logic        wrEn;
    logic [3:0]  wrSel;
    logic [4:0]  wrAddr;
    logic [31:0] wrData;
    logic [4:0]  scanAddr;
    logic [31:0] scanData;
    logic [4:0]  busAddr;
    logic [31:0] busData;

    modport mem  (input wrEn, wrSel, wrAddr, wrData, scanAddr, busAddr,
                  output scanData, busData);
    modport user (output wrEn, wrSel, wrAddr, wrData, scanAddr, busAddr,
                  input scanData, busData);
endinterface
`default_nettype wire

/* rtl/pre_rung_mem.sv */
// Rung word store: one byte-lane write port, two registered read ports
// Assumes writes and reads on the same clock; no reset of contents
`timescale 1ns/10ps
`default_nettype none
module pre_rung_mem (
    // Clock
    input wire logic core_clk,
    // Access ports
    pre_mem_if.mem   mp
);
    // One store per lane, so each array has a single writing process
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_lane
            logic [7:0] laneStore [0:31];
            logic [7:0] scanByte_reg;
            logic [7:0] busByte_reg;

            always_ff @(posedge core_clk) begin
                if (mp.wrEn && mp.wrSel[b]) begin
                    laneStore[mp.wrAddr] <= mp.wrData[8*b +: 8];
                end
                scanByte_reg <= laneStore[mp.scanAddr];
                busByte_reg  <= laneStore[mp.busAddr];
            end

            assign mp.scanData[8*b +: 8] = scanByte_reg;
            assign mp.busData[8*b +: 8]  = busByte_reg;
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/pre_cond_eval.sv */
// Combines the two conditions of one rung word through its operator
// Assumes inputs and variables are stable while the rung is evaluated
`timescale 1ns/10ps
`default_nettype none
`include "pre_map.svh"
module pre_cond_eval (
    // Rung and operands
    input  wire logic [31:0] rung,
    input  wire logic [7:0]  din,
    input  wire logic [9:0]  vars,
    // Result
    output logic             result
);
    logic [7:0] codeA;
    logic [7:0] codeB;
    logic [7:0] oper;
    logic       valA;
    logic       valB;

    // Unknown codes read as false
    function automatic logic condVal(input logic [7:0] code,
                                     input logic [7:0] dIn,
                                     input logic [9:0] v);
        logic [7:0] off;
        condVal = 1'b0;
        off     = 8'h00;
        if (code == `PRE_CND_TRUE) begin // see [R13]
            condVal = 1'b1;
        end else if (code >= `PRE_CND_IN_BASE &&
                     code < `PRE_CND_IN_BASE + 8'h08) begin
            off     = code - `PRE_CND_IN_BASE;
            condVal = dIn[off[2:0]];
        end else if (code >= `PRE_CND_VAR_BASE &&
                     code < `PRE_CND_VAR_BASE + 8'h0a) begin
            off     = code - `PRE_CND_VAR_BASE;
            condVal = v[off[3:0]];
        end
    endfunction

    assign codeA = rung[`PRE_RUNG_CA_LSB +: 8];  // see [R4]
    assign oper  = rung[`PRE_RUNG_LOG_LSB +: 8];
    assign codeB = rung[`PRE_RUNG_CB_LSB +: 8];
    assign valA  = condVal(codeA, din, vars);
    assign valB  = condVal(codeB, din, vars);

    always_comb begin
        if (oper == `PRE_LOG_AND) begin // see [R13]
            result = valA & valB;
        end else if (oper == `PRE_LOG_XOR) begin
            result = valA ^ valB;
        end else if (oper == `PRE_LOG_NOR) begin // see [R6]
            result = ~(valA | valB);
        end else begin
            result = valA | valB; // see [R7]
        end
    end
endmodule
`default_nettype wire

/* rtl/pre_rung_eval.sv */
// Rung evaluator top: Wishbone registers, rung scan, action outputs
// Assumes digital inputs and enable are synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
`include "pre_map.svh"
// Notes on behaviour
// [R1] Actions 28 down to 25 form a four-bit preset index, 0..14 = presets 1..15.
// [R2] A preset index of fifteen commands zero speed instead of a preset.
// [R3] Actions 36 and 35 form a two-bit index picking parameter table one..four.
// [R4] A rung word is condition A, operator, condition B, action, high byte first.
// [R5] With the preset source active and no index bits set the index is zero.
// [R6] Input 8 NOR false driving the fault action faults while input 8 is low.
// [R7] OR of two inputs drives jog enable; separate rungs pick the jog direction.
// [R8] Rungs are evaluated only while the mode field holds the PLC value.
// [R9] The enable input still gates running regardless of rung results.
// [R10] Rungs run in ascending order so earlier variable writes are seen later.
// [R11] A variable action sets its variable when true and clears it when false.
// [R12] Action 69 clears every logical variable when its condition is true.
// [R13] Operators are 0 OR, 1 AND, 2 XOR, 3 NOR; conditions are false, true, inputs, vars.
// [R14] One full scan per period, with all drive actions committed together at its end; variables change as rungs run.
module pre_rung_eval #(
    parameter int SCAN_CYCLES = `PRE_SCAN_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic             ack_o,
    output logic [31:0]      dat_o,
    // Field inputs
    input  wire logic [7:0]  digIn,
    input  wire logic        enableIn,
    // Drive commands
    output logic             runFwd,
    output logic             runRev,
    output logic             jogEn,
    output logic             jogFwd,
    output logic             jogRev,
    output logic             fault,
    output logic             faultReset,
    output logic             accelGroup,
    output logic             presetSrc,
    output logic [3:0]       presetIdx,
    output logic             zeroSpeed,
    output logic             paramTableSel,
    output logic [1:0]       paramTableIdx,
    // Interrupt
    output logic             irq
);
    pre_mem_if memBus ();

    logic [31:0]        ctrl_reg;
    logic [1:0]         irqMask_reg;
    logic [1:0]         irqStat_reg;
    logic               busPend_reg;
    logic [31:0]        tick_reg;
    logic               tick;
    pre_pkg::pre_state_t state_reg;
    logic [4:0]         rungIdx_reg;
    logic [9:0]         vars_reg;
    pre_pkg::pre_act_t  shadow_reg;
    pre_pkg::pre_act_t  act_reg;
    logic               faultPrev_reg;
    logic               result;
    logic [7:0]         actCode;
    logic [7:0]         actOff;
    logic               plcMode;
    logic               busDo;
    logic               busWr;
    logic               rungHit;
    logic [31:0]        busMask;
    logic [31:0]        rdMux;
    logic [1:0]         irqSet;
    logic [1:0]         irqClr;
    logic               scanDone;

    assign plcMode = ctrl_reg[`PRE_CTRL_MODE_MSB:`PRE_CTRL_MODE_LSB]
                     == `PRE_MODE_PLC;
    assign busDo   = busPend_reg;
    assign busWr   = busDo && we_i;
    assign rungHit = adr_i >= `PRE_OFF_RUNG_BASE;
    assign busMask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign actCode = memBus.scanData[`PRE_RUNG_ACT_LSB +: 8]; // see [R4]
    assign actOff  = actCode - `PRE_ACT_PRE_B0;

    // Rung words live in their own store
    assign memBus.wrEn     = busWr && rungHit;
    assign memBus.wrSel    = sel_i;
    assign memBus.wrAddr   = adr_i[6:2];
    assign memBus.wrData   = dat_i;
    assign memBus.busAddr  = adr_i[6:2];
    assign memBus.scanAddr = rungIdx_reg;

    pre_rung_mem u_mem (
        .core_clk (core_clk),
        .mp       (memBus.mem)
    );

    pre_cond_eval u_cond (
        .rung   (memBus.scanData),
        .din    (digIn),
        .vars   (vars_reg),
        .result (result)
    );

    // Read mux; unmapped words read as zero
    always_comb begin
        rdMux = 32'h0000_0000;
        if (rungHit) begin
            rdMux = memBus.busData;
        end else if (adr_i == `PRE_OFF_CTRL) begin
            rdMux = ctrl_reg;
        end else if (adr_i == `PRE_OFF_STATE) begin
            rdMux = {15'h0000, state_reg != pre_pkg::SC_IDLE, act_reg};
        end else if (adr_i == `PRE_OFF_VARS) begin
            rdMux = {22'h000000, vars_reg};
        end else if (adr_i == `PRE_OFF_IRQ_STAT) begin
            rdMux = {30'h00000000, irqStat_reg};
        end else if (adr_i == `PRE_OFF_IRQ_MASK) begin
            rdMux = {30'h00000000, irqMask_reg};
        end
    end

    // Two-cycle answer gives the store time to read
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busPend_reg <= 1'b0;
            ack_o       <= 1'b0;
            dat_o       <= 32'h0000_0000;
        end else begin
            busPend_reg <= cyc_i && stb_i && !busPend_reg && !ack_o;
            ack_o       <= busDo;
            if (busDo && !we_i) begin
                dat_o <= rdMux;
            end
        end
    end

    // Control and mask registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_reg    <= `PRE_CTRL_RESET;
            irqMask_reg <= `PRE_MASK_RESET;
        end else if (busWr) begin
            if (adr_i == `PRE_OFF_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~busMask) | (dat_i & busMask);
            end else if (adr_i == `PRE_OFF_IRQ_MASK && sel_i[0]) begin
                irqMask_reg <= dat_i[1:0];
            end
        end
    end

    // Scan period divider
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tick_reg <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (tick_reg == 32'(SCAN_CYCLES - 1)) begin
            tick_reg <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // Scan sequencer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg   <= pre_pkg::SC_IDLE;
            rungIdx_reg <= 5'h00;
        end else if (!plcMode) begin // see [R8]
            state_reg   <= pre_pkg::SC_IDLE;
            rungIdx_reg <= 5'h00;
        end else begin
            case (state_reg)
                pre_pkg::SC_IDLE: begin
                    if (tick) begin // see [R14]
                        state_reg   <= pre_pkg::SC_FETCH;
                        rungIdx_reg <= 5'h00; // see [R10]
                    end
                end
                pre_pkg::SC_FETCH: begin
                    state_reg <= pre_pkg::SC_EXEC;
                end
                pre_pkg::SC_EXEC: begin
                    // Last index lowered mid-scan ends the scan at once
                    if (rungIdx_reg >=
                        ctrl_reg[`PRE_CTRL_LAST_MSB:`PRE_CTRL_LAST_LSB]) begin
                        state_reg <= pre_pkg::SC_COMMIT;
                    end else begin
                        state_reg   <= pre_pkg::SC_FETCH;
                        rungIdx_reg <= rungIdx_reg + 5'h01; // see [R10]
                    end
                end
                default: begin
                    state_reg <= pre_pkg::SC_IDLE;
                end
            endcase
        end
    end

    // Logical variables persist across scans
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            vars_reg <= 10'h000;
        end else if (plcMode && state_reg == pre_pkg::SC_EXEC) begin
            if (actCode == `PRE_ACT_PLC_RST) begin
                if (result) begin
                    vars_reg <= 10'h000; // see [R12]
                end
            end else if (actCode >= `PRE_ACT_VAR_BASE &&
                         actCode < `PRE_ACT_VAR_BASE + 8'h0a) begin
                vars_reg[4'(actCode - `PRE_ACT_VAR_BASE)] <= result; // see [R11]
            end
        end
    end

    // Actions build up in a shadow during the scan
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            shadow_reg <= '0;
        end else if (state_reg == pre_pkg::SC_IDLE) begin
            shadow_reg <= '0; // see [R5]
        end else if (state_reg == pre_pkg::SC_EXEC) begin
            case (actCode)
                `PRE_ACT_JOG_REV:  shadow_reg.jogRev     <= result; // see [R7]
                `PRE_ACT_JOG_FWD:  shadow_reg.jogFwd     <= result; // see [R7]
                `PRE_ACT_JOG_EN:   shadow_reg.jogEn      <= result; // see [R7]
                `PRE_ACT_FAULT:    shadow_reg.fault      <= result; // see [R6]
                `PRE_ACT_FWD:      shadow_reg.runFwd     <= result;
                `PRE_ACT_REV:      shadow_reg.runRev     <= result;
                `PRE_ACT_ACC_GRP:  shadow_reg.accelGroup <= result;
                `PRE_ACT_FLT_RST:  shadow_reg.faultReset <= result;
                `PRE_ACT_PRE_SRC:  shadow_reg.presetSrc  <= result; // see [R5]
                `PRE_ACT_PTAB_SEL: shadow_reg.ptabSel    <= result;
                `PRE_ACT_PTAB_B0:  shadow_reg.ptabIdx[0] <= result; // see [R3]
                `PRE_ACT_PTAB_B1:  shadow_reg.ptabIdx[1] <= result; // see [R3]
                default: begin
                    if (actCode >= `PRE_ACT_PRE_B0 &&
                        actCode <= `PRE_ACT_PRE_B3) begin
                        shadow_reg.presetIdx[actOff[1:0]] <= result; // see [R1]
                    end
                end
            endcase
        end
    end

    // Committed actions change only at the end of a scan, or clear when the mode leaves PLC
    assign scanDone = state_reg == pre_pkg::SC_COMMIT;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            act_reg <= '0;
        end else if (!plcMode) begin
            act_reg <= '0; // see [R8]
        end else if (scanDone) begin
            act_reg <= shadow_reg; // see [R14]
        end
    end

    // Drive commands; enable still holds off motion
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            runFwd        <= 1'b0;
            runRev        <= 1'b0;
            jogEn         <= 1'b0;
            jogFwd        <= 1'b0;
            jogRev        <= 1'b0;
            fault         <= 1'b0;
            faultReset    <= 1'b0;
            accelGroup    <= 1'b0;
            presetSrc     <= 1'b0;
            presetIdx     <= 4'h0;
            zeroSpeed     <= 1'b0;
            paramTableSel <= 1'b0;
            paramTableIdx <= 2'h0;
        end else begin
            runFwd        <= enableIn && act_reg.runFwd; // see [R9]
            runRev        <= enableIn && act_reg.runRev; // see [R9]
            jogEn         <= enableIn && act_reg.jogEn;  // see [R9]
            jogFwd        <= act_reg.jogFwd;
            jogRev        <= act_reg.jogRev;
            fault         <= act_reg.fault;
            faultReset    <= act_reg.faultReset;
            accelGroup    <= act_reg.accelGroup;
            presetSrc     <= act_reg.presetSrc;
            presetIdx     <= act_reg.presetIdx; // see [R1]
            zeroSpeed     <= act_reg.presetSrc &&
                             act_reg.presetIdx == `PRE_PRESET_ZERO; // see [R2]
            paramTableSel <= act_reg.ptabSel;
            paramTableIdx <= act_reg.ptabIdx; // see [R3]
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    assign irqSet[`PRE_IRQ_SCAN]  = scanDone;
    assign irqSet[`PRE_IRQ_FAULT] = act_reg.fault && !faultPrev_reg;
    assign irqClr = (busWr && adr_i == `PRE_OFF_IRQ_STAT && sel_i[0])
                    ? dat_i[1:0] : 2'h0;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irqStat_reg   <= 2'h0;
            faultPrev_reg <= 1'b0;
            irq           <= 1'b0;
        end else begin
            irqStat_reg   <= (irqStat_reg & ~irqClr) | irqSet;
            faultPrev_reg <= act_reg.fault;
            irq           <= |(irqStat_reg & irqMask_reg);
        end
    end
endmodule
`default_nettype wire

/* testbench/pre_rung_eval_props.sv */
// Port checker for the rung evaluator top
// Assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module pre_rung_eval_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    // Field and drive
    input wire logic        enableIn,
    input wire logic        runFwd,
    input wire logic        runRev,
    input wire logic        jogEn,
    input wire logic        presetSrc,
    input wire logic [3:0]  presetIdx,
    input wire logic        zeroSpeed
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_zero_idx;
        zeroSpeed |-> presetSrc && presetIdx == 4'hf;
    endproperty
    a_zero_idx: assert property (p_zero_idx)
        else $error("zero speed without index fifteen");
    property p_zero_cause;
        (presetSrc && presetIdx == 4'hf) |-> zeroSpeed;
    endproperty
    a_zero_cause: assert property (p_zero_cause)
        else $error("index fifteen without zero speed");
    property p_run_gate;
        (runFwd || runRev) |-> $past(enableIn);
    endproperty
    a_run_gate: assert property (p_run_gate)
        else $error("run command while enable open");
    property p_enable_drop;
        $fell(enableIn) |=> !jogEn && !runFwd && !runRev;
    endproperty
    a_enable_drop: assert property (p_enable_drop)
        else $error("run or jog kept after enable dropped");
    property p_ack_lat;
        $rose(cyc_i && stb_i) |-> !ack_o ##1 !ack_o ##1 ack_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("bus answer not two cycles after request");
    property p_ack_one;
        ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("acknowledge longer than one cycle");
    property p_ack_cause;
        ack_o |-> cyc_i && $past(cyc_i && stb_i, 2);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without a request");
    property p_rdata_hold;
        $changed(dat_o) |-> ack_o && !we_i;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed outside a read answer");
endmodule

bind pre_rung_eval pre_rung_eval_props u_pre_rung_eval_props (
    .core_clk(core_clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .ack_o(ack_o), .dat_o(dat_o), .enableIn(enableIn),
    .runFwd(runFwd), .runRev(runRev), .jogEn(jogEn),
    .presetSrc(presetSrc), .presetIdx(presetIdx), .zeroSpeed(zeroSpeed)
);
`default_nettype wire

/* testbench/pre_field_model.sv */
// Field model: input switches and enable contact ahead of the evaluator
// Assumes the bench sets contact states; terminals follow on core_clk
`timescale 1ns/10ps
`default_nettype none
module pre_field_model (
    // Clock
    input  wire logic       core_clk,
    // Requested contact states
    input  wire logic [7:0] swIn,
    input  wire logic       enReq,
    // Terminals toward the evaluator
    output logic [7:0]      digIn,
    output logic            enableIn
);
    // Registered, so terminals move only on core_clk, the evaluator's sampling edge
    always_ff @(posedge core_clk) begin
        digIn <= swIn;
    end
    // Drive only runs while this contact is closed
    always_ff @(posedge core_clk) begin
        enableIn <= enReq;
    end
endmodule
`default_nettype wire

/* testbench/pre_rung_eval_test.sv */
// Self-checking bench for the rung evaluator
// Assumes the field model feeds inputs; scan shortened to 64 cycles
`timescale 1ns/10ps
`default_nettype none
`include "pre_map.svh"
module pre_rung_eval_test;
    localparam int SCAN = 64;
    logic        core_clk;
    logic        reset_n;
    logic        cyc, stb, we, ack, irq, zeroSpeed, enReq, enableIn;
    logic [7:0]  adr, sw, digIn;
    logic [31:0] wdat, dout, rdat;
    logic [15:0] pins, e;
    int          error_cnt, tests_run, i;
    // Last two rungs reach the XOR operator, accel group and fault reset
    logic [31:0] prog [19] = '{32'h32000014, 32'h33000015, 32'h34003512,
        32'h34000006, 32'h35000005, 32'h37000018, 32'h39030013,
        32'h01000022, 32'h35000023, 32'h36000024, 32'h32013328,
        32'h64000029, 32'h38000045, 32'h34000019, 32'h3500001a,
        32'h3600001b, 32'h3700001c, 32'h38000016, 32'h36023717};
    logic [7:0]  pat [8] = '{8'h00, 8'h81, 8'h3f, 8'h43, 8'h8c, 8'h23,
        8'h95, 8'hd2};

    pre_rung_eval #(.SCAN_CYCLES(SCAN)) u_pre_rung_eval (
        .core_clk(core_clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .ack_o(ack),
        .dat_o(dout), .digIn(digIn), .enableIn(enableIn),
        .runFwd(pins[15]), .runRev(pins[14]), .jogEn(pins[13]),
        .jogFwd(pins[12]), .jogRev(pins[11]), .fault(pins[10]),
        .faultReset(pins[9]), .accelGroup(pins[8]), .presetSrc(pins[7]),
        .presetIdx(pins[6:3]), .zeroSpeed(zeroSpeed),
        .paramTableSel(pins[2]), .paramTableIdx(pins[1:0]), .irq(irq));
    pre_field_model u_pre_field_model (.core_clk(core_clk), .swIn(sw),
        .enReq(enReq), .digIn(digIn), .enableIn(enableIn));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is sampled, then a one-cycle gap
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) error_cnt++;
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    // Two completed scans guarantee one that started after the change
    task automatic scan2();
        int n;
        repeat (2) begin
            wb(1'b1, `PRE_OFF_IRQ_STAT, 32'h3);
            n = 0;
            while (irq !== 1'b1 && n < 400) begin
                @(posedge core_clk);
                n++;
            end
            if (irq !== 1'b1) error_cnt++;
        end
    endtask

    function automatic logic [15:0] expAct(input logic [7:0] d);
        return {d[0], d[1], d[2] | d[3], d[2], d[3], ~d[7], d[4] ^ d[5],
                d[6], d[5], d[5], d[4], d[3], d[2], 1'b1, d[4], d[3]};
    endfunction

    task automatic close_out();
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    initial begin
        error_cnt = 0;
        tests_run = 0;
        reset_n = 1'b0;
        {cyc, stb, we, adr, wdat, sw, enReq} = '0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(`PRE_OFF_CTRL, 32'h0);
        rd(`PRE_OFF_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        check(pins, 16'h0);
        for (i = 0; i < 19; i++)
            wb(1'b1, `PRE_OFF_RUNG_BASE + 8'(4 * i), prog[i]);
        wb(1'b1, `PRE_OFF_IRQ_MASK, 32'h1);
        wb(1'b1, `PRE_OFF_CTRL, {19'h0, 5'd18, 4'h0, `PRE_MODE_PLC});
        rd(`PRE_OFF_CTRL, {19'h0, 5'd18, 4'h0, `PRE_MODE_PLC});
        for (i = 0; i < 8; i++) begin
            sw <= pat[i];
            enReq <= (i != 6);
            scan2();
            e = expAct(pat[i]);
            wb(1'b0, `PRE_OFF_STATE, 32'h0);
            check(rdat[15:0], e);
            check(pins, e & {{3{i != 6}}, 13'h1fff});
            check(zeroSpeed, pat[i][5:2] == 4'hf);
            rd(`PRE_OFF_VARS, {30'h0, {2{&pat[i][1:0] & ~pat[i][6]}}});
        end
        wb(1'b1, `PRE_OFF_CTRL, {19'h0, 5'd6, 4'h0, `PRE_MODE_PLC});
        sw <= 8'hbc;
        scan2();
        check(pins[7:3], 5'h10);
        check(zeroSpeed, 1'b0);
        wb(1'b1, `PRE_OFF_IRQ_MASK, 32'h0);
        repeat (3 * SCAN) @(posedge core_clk);
        check(irq, 1'b0);
        wb(1'b0, `PRE_OFF_IRQ_STAT, 32'h0);
        check(rdat[0], 1'b1);
        wb(1'b1, `PRE_OFF_IRQ_MASK, 32'h1);
        check(irq, 1'b1);
        wb(1'b1, `PRE_OFF_CTRL, {19'h0, 5'd6, 4'h0, 4'h4});
        wb(1'b1, `PRE_OFF_IRQ_STAT, 32'h3);
        repeat (3 * SCAN) @(posedge core_clk);
        check({pins, zeroSpeed, irq}, 18'h0);
        rd(`PRE_OFF_IRQ_STAT, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
